// ### dcfd_config.sv
// configuration byte bank, table access port and static setting decoder
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module dcfd_config
  import dcfd_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  input  wire logic              bulk_erase_i,
  output logic [7:0]             rdata_o,
  input  wire logic              eight_output_pkg_i,
  input  wire logic              watchdog_soft_en_i,
  input  wire logic              stack_full_i,
  input  wire logic              stack_underflow_i,
  input  wire logic              external_reset_pin_i,
  input  wire logic [7:0]        pwm_drive_i,
  input  wire logic [7:0]        pwm_force_i,
  input  wire logic [7:0]        pwm_force_active_i,
  output logic                   brownout_reset_en_o,
  output logic [1:0]             brownout_threshold_sel_o,
  output logic [12:0]            brownout_trip_level_o,
  output logic                   powerup_timer_en_o,
  output logic                   watchdog_window_en_o,
  output logic [3:0]             watchdog_postscale_sel_o,
  output logic [15:0]            watchdog_divide_o,
  output logic                   watchdog_run_o,
  output logic                   timer1_osc_lowpower_o,
  output logic                   high_side_polarity_o,
  output logic                   low_side_polarity_o,
  output logic                   pwm_reset_state_sel_o,
  output logic [2:0]             pwm_output_enable_field_o,
  output logic [7:0]             pwm_pin_o,
  output logic [7:0]             pwm_pin_oe_o,
  output logic                   reset_pin_en_o,
  output logic                   external_reset_o,
  output logic                   shared_pin_gp_o,
  output logic                   timer_ext_clock_pin_sel_o,
  output logic                   pwm4_pin_sel_o,
  output logic                   sync_serial_pin_sel_o,
  output logic                   fault_a_pin_sel_o,
  output logic                   debug_en_o,
  output logic                   single_supply_prog_en_o,
  output logic                   stack_error_reset_o,
  output logic [3:0]             block_protect_o,
  output logic                   eeprom_protect_o,
  output logic                   boot_block_protect_o
);

  function automatic dcfd_idx_t reg_idx(input logic [ADDR_W-1:0] a);
    dcfd_idx_t r;
    r = IDX_NONE;
    if (a >= CFG_BASE && a <= CFG_LAST) begin
      unique case (a)
        BOR_PWR_OFF: r = IDX_BOR;
        WDT_OFF:     r = IDX_WDT;
        TMR_PWM_OFF: r = IDX_TMR;
        PIN_MUX_OFF: r = IDX_PIN;
        DBG_STK_OFF: r = IDX_DBG;
        BLK_CP_OFF:  r = IDX_CP;
        EE_BOOT_OFF: r = IDX_CPEB;
        default:     r = IDX_NONE;
      endcase
    end
    return r;
  endfunction

  function automatic logic [12:0] trip_mv(input logic [1:0] sel);
    unique case (sel)
      2'h0:    return TRIP_4V5_MV;
      2'h1:    return TRIP_4V2_MV;
      default: return TRIP_2V7_MV;
    endcase
  endfunction

  logic [7:0] nv_q [7];
  dcfd_idx_t  acc_idx;
  assign acc_idx = reg_idx(addr_i);

  // non-volatile bytes: keep their contents across reset
  always_ff @(posedge clk_i) begin
    if (bulk_erase_i) begin
      for (int i = 0; i < 7; i++) begin
        nv_q[i] <= REG_MASK[i];
      end
    end else if (rst_n_i && wr_i && acc_idx != IDX_NONE) begin
      if (acc_idx == IDX_CP || acc_idx == IDX_CPEB) begin
        nv_q[acc_idx] <= nv_q[acc_idx] & wdata_i;
      end else begin
        nv_q[acc_idx] <= wdata_i & REG_MASK[acc_idx];
      end
    end
  end

  logic [7:0] rdata_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !rd_i || acc_idx == IDX_NONE) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= nv_q[acc_idx] & REG_MASK[acc_idx];
    end
  end
  assign rdata_o = rdata_q;

  // settings load while reset is held, then stay static
  logic [7:0] bor_q, wdt_q, tmr_q, pin_q, dbg_q, cp_q, cpeb_q;
  logic       eight_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bor_q   <= nv_q[IDX_BOR];
      wdt_q   <= nv_q[IDX_WDT];
      tmr_q   <= nv_q[IDX_TMR];
      pin_q   <= nv_q[IDX_PIN];
      dbg_q   <= nv_q[IDX_DBG];
      cp_q    <= nv_q[IDX_CP];
      cpeb_q  <= nv_q[IDX_CPEB];
      eight_q <= eight_output_pkg_i;
    end
  end

  assign brownout_reset_en_o       = bor_q[BROWNOUT_RESET_EN_BIT];
  assign brownout_threshold_sel_o  = bor_q[BORV_LSB+:2];
  assign powerup_timer_en_o        = !bor_q[POWERUP_TIMER_EN_N_BIT];
  assign watchdog_window_en_o      = !wdt_q[WATCHDOG_WINDOW_EN_N_BIT];
  assign watchdog_postscale_sel_o  = wdt_q[WDTPS_LSB+:4];
  assign timer1_osc_lowpower_o     = tmr_q[T1OSC_BIT];
  assign high_side_polarity_o      = tmr_q[HIGH_SIDE_POLARITY_BIT];
  assign low_side_polarity_o       = tmr_q[LOW_SIDE_POLARITY_BIT];
  assign pwm_reset_state_sel_o     = tmr_q[PWM_RESET_STATE_SEL_BIT];
  assign reset_pin_en_o            = pin_q[RESET_PIN_EN_BIT];
  assign timer_ext_clock_pin_sel_o = pin_q[EXCLK_BIT];
  assign pwm4_pin_sel_o            = pin_q[PWM4_BIT];
  assign sync_serial_pin_sel_o     = pin_q[SSP_BIT];
  assign fault_a_pin_sel_o         = pin_q[FAULT_INPUT_A_BIT];
  assign debug_en_o                = !dbg_q[DEBUG_BIT];
  assign single_supply_prog_en_o   = dbg_q[LVP_BIT];
  assign block_protect_o           = ~cp_q[3:0];
  assign eeprom_protect_o          = !cpeb_q[CPD_BIT];
  assign boot_block_protect_o      = !cpeb_q[CPB_BIT];

  logic [12:0] trip_q;
  logic [15:0] divide_q;
  always_ff @(posedge clk_i) begin
    trip_q   <= trip_mv(bor_q[BORV_LSB+:2]);
    divide_q <= 16'h0001 << bor_wdt_sel(wdt_q);
  end
  assign brownout_trip_level_o = trip_q;
  assign watchdog_divide_o     = divide_q;

  function automatic logic [3:0] bor_wdt_sel(input logic [7:0] b);
    return b[WDTPS_LSB+:4];
  endfunction

  logic run_q, stk_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      run_q <= 1'b0;
      stk_q <= 1'b0;
    end else begin
      run_q <= wdt_q[WATCHDOG_FORCE_EN_BIT] | watchdog_soft_en_i;
      stk_q <= dbg_q[STVR_BIT] & (stack_full_i | stack_underflow_i);
    end
  end
  assign watchdog_run_o      = run_q;
  assign stack_error_reset_o = stk_q;

  // shared reset pin: two-stage sync, the pin is low-active as a reset
  logic pin_s1_q, pin_s2_q, ext_rst_q, gp_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_s1_q  <= 1'b1;
      pin_s2_q  <= 1'b1;
      ext_rst_q <= 1'b0;
      gp_q      <= 1'b0;
    end else begin
      pin_s1_q  <= external_reset_pin_i;
      pin_s2_q  <= pin_s1_q;
      ext_rst_q <= reset_pin_en_o & !pin_s2_q;
      gp_q      <= !reset_pin_en_o & pin_s2_q;
    end
  end
  assign external_reset_o = ext_rst_q;
  assign shared_pin_gp_o  = gp_q;

  // PWM enable field and pin drive
  logic [2:0] pwmen_q;
  logic [7:0] oe_q, pwm_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      if (nv_q[IDX_TMR][PWM_RESET_STATE_SEL_BIT]) begin
        pwmen_q <= PWMEN_OFF;
        oe_q    <= 8'h00;
      end else if (eight_output_pkg_i) begin
        pwmen_q <= PWMEN_EIGHT;
        oe_q    <= 8'hFF;
      end else begin
        pwmen_q <= PWMEN_SIX;
        oe_q    <= 8'h3F;
      end
    end
  end
  assign pwm_output_enable_field_o = pwmen_q;
  assign pwm_pin_oe_o              = oe_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pwm_q <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        // odd outputs are high side, even are low side
        pwm_q[i] <= oe_q[i] & (pwm_level(i[0], pwm_force_i[i] ?
                    pwm_force_active_i[i] : pwm_drive_i[i]));
      end
    end
  end
  assign pwm_pin_o = pwm_q;

  function automatic logic pwm_level(input logic odd, input logic act);
    return odd ? (act == high_side_polarity_o)
               : (act == low_side_polarity_o);
  endfunction

  sequence s_cp_write;
    wr_i && !bulk_erase_i && acc_idx == IDX_CP;
  endsequence

  sequence s_pin_low;
    !external_reset_pin_i [*3];
  endsequence

  sequence s_released;
    $rose(rst_n_i);
  endsequence

  chk_hold_static: assert property (@(posedge clk_i)
    rst_n_i && $past(rst_n_i) |-> $stable({bor_q, wdt_q, tmr_q, cp_q}))
    else $error("settings changed while running");

  chk_bor_enable: assert property (@(posedge clk_i)
    $rose(rst_n_i) |-> brownout_reset_en_o == $past(nv_q[IDX_BOR][BROWNOUT_RESET_EN_BIT]))
    else $error("brown-out enable not captured");

  chk_powerup_timer_indep: assert property (@(posedge clk_i)
    $rose(rst_n_i) |-> powerup_timer_en_o == !$past(nv_q[IDX_BOR][POWERUP_TIMER_EN_N_BIT]))
    else $error("power-up timer enable wrong");

  chk_trip_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) && brownout_threshold_sel_o[1] |=> brownout_trip_level_o == TRIP_2V7_MV)
    else $error("reserved or 2.7V threshold wrong");

  chk_wdt_divide: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) |=> watchdog_divide_o == 16'h0001 << watchdog_postscale_sel_o)
    else $error("watchdog divide wrong");

  chk_wdt_run: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) |-> watchdog_run_o == (wdt_q[WATCHDOG_FORCE_EN_BIT] | $past(watchdog_soft_en_i)))
    else $error("watchdog run wrong");

  chk_cp_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_cp_write |=> nv_q[IDX_CP] == ($past(nv_q[IDX_CP]) & $past(wdata_i)))
    else $error("protection bit set by write");

  chk_ext_reset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_pin_low |=> external_reset_o == reset_pin_en_o)
    else $error("external reset not seen");

  chk_stack_rst: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) && (stack_full_i || stack_underflow_i) |=>
      stack_error_reset_o == dbg_q[STVR_BIT])
    else $error("stack reset wrong");

  chk_pwm_enable: assert property (@(posedge clk_i)
    $rose(rst_n_i) && !$past(nv_q[IDX_TMR][PWM_RESET_STATE_SEL_BIT]) |->
      pwm_output_enable_field_o == ($past(eight_output_pkg_i) ? PWMEN_EIGHT : PWMEN_SIX))
    else $error("pwm enable field wrong");

  chk_pwm_odd: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) && oe_q[1] && !pwm_force_i[1] |=>
      pwm_pin_o[1] == ($past(pwm_drive_i[1]) == high_side_polarity_o))
    else $error("odd pwm polarity wrong");

  chk_pwm_force: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) && oe_q[0] && pwm_force_i[0] |=>
      pwm_pin_o[0] == ($past(pwm_force_active_i[0]) == low_side_polarity_o))
    else $error("forced pwm level wrong");

  chk_unimpl_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_i && addr_i == BOR_PWR_OFF |=> rdata_o[7:4] == 4'h0)
    else $error("unimplemented bits read nonzero");

  chk_unmapped_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_i && acc_idx == IDX_NONE |=> rdata_o == 8'h00)
    else $error("unmapped read nonzero");

  chk_window_en: assert property (@(posedge clk_i)
    s_released |-> watchdog_window_en_o == !$past(nv_q[IDX_WDT][WATCHDOG_WINDOW_EN_N_BIT]))
    else $error("window enable not captured");

  chk_postscale_sel: assert property (@(posedge clk_i)
    s_released |-> watchdog_postscale_sel_o == $past(nv_q[IDX_WDT][WDTPS_LSB+:4]))
    else $error("postscale select not captured");

  chk_t1_osc: assert property (@(posedge clk_i)
    s_released |-> timer1_osc_lowpower_o == $past(nv_q[IDX_TMR][T1OSC_BIT]))
    else $error("timer1 oscillator mode not captured");

  chk_pwm_off: assert property (@(posedge clk_i)
    s_released && $past(nv_q[IDX_TMR][PWM_RESET_STATE_SEL_BIT]) |->
      pwm_pin_oe_o == 8'h00 && pwm_output_enable_field_o == PWMEN_OFF)
    else $error("pwm not disabled after reset");

  chk_pwm_even: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) && oe_q[2] && !pwm_force_i[2] |=>
      pwm_pin_o[2] == ($past(pwm_drive_i[2]) == low_side_polarity_o))
    else $error("even pwm polarity wrong");

  chk_reset_pin_en: assert property (@(posedge clk_i)
    s_released |-> reset_pin_en_o == $past(nv_q[IDX_PIN][RESET_PIN_EN_BIT]))
    else $error("reset pin enable not captured");

  chk_mux_capture: assert property (@(posedge clk_i)
    s_released |-> fault_a_pin_sel_o == $past(nv_q[IDX_PIN][FAULT_INPUT_A_BIT]) &&
      sync_serial_pin_sel_o == $past(nv_q[IDX_PIN][SSP_BIT]))
    else $error("pin mux select not captured");

  chk_pin_general: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) && !reset_pin_en_o |-> !external_reset_o)
    else $error("external reset while pin is general input");

  chk_debug_en: assert property (@(posedge clk_i)
    s_released |-> debug_en_o == !$past(nv_q[IDX_DBG][DEBUG_BIT]))
    else $error("debugger enable not captured");

  chk_lvp_en: assert property (@(posedge clk_i)
    s_released |-> single_supply_prog_en_o == $past(nv_q[IDX_DBG][LVP_BIT]))
    else $error("single-supply enable not captured");

  chk_block_prot: assert property (@(posedge clk_i)
    s_released |-> block_protect_o == ~$past(nv_q[IDX_CP][3:0]))
    else $error("block protection not captured");

  chk_region_prot: assert property (@(posedge clk_i)
    s_released |-> {eeprom_protect_o, boot_block_protect_o} ==
      ~{$past(nv_q[IDX_CPEB][CPD_BIT]), $past(nv_q[IDX_CPEB][CPB_BIT])})
    else $error("region protection not captured");

endmodule // dcfd_config

// ### dcfd_pkg.sv
// constants for the configuration byte bank and its decoder
package dcfd_pkg;

  localparam int ADDR_W = 22;

  // configuration space, reached by table access only
  localparam logic [21:0] CFG_BASE = 22'h300000;
  localparam logic [21:0] CFG_LAST = 22'h3FFFFF;

  localparam logic [21:0] BOR_PWR_OFF  = 22'h300002;
  localparam logic [21:0] WDT_OFF      = 22'h300003;
  localparam logic [21:0] TMR_PWM_OFF  = 22'h300004;
  localparam logic [21:0] PIN_MUX_OFF  = 22'h300005;
  localparam logic [21:0] DBG_STK_OFF  = 22'h300006;
  localparam logic [21:0] BLK_CP_OFF   = 22'h300008;
  localparam logic [21:0] EE_BOOT_OFF  = 22'h300009;

  typedef enum logic [2:0] {
    IDX_BOR, IDX_WDT, IDX_TMR, IDX_PIN, IDX_DBG, IDX_CP, IDX_CPEB, IDX_NONE
  } dcfd_idx_t;

  // implemented bits; also the unprogrammed (erased) value of each byte
  localparam logic [7:0] REG_MASK [8] = '{
    8'h0F, 8'h3F, 8'h3C, 8'h9D, 8'h85, 8'h0F, 8'hC0, 8'h00
  };

  localparam int BORV_LSB   = 2;
  localparam int BROWNOUT_RESET_EN_BIT  = 1;
  localparam int POWERUP_TIMER_EN_N_BIT = 0;
  localparam int WATCHDOG_WINDOW_EN_N_BIT  = 5;
  localparam int WDTPS_LSB  = 1;
  localparam int WATCHDOG_FORCE_EN_BIT  = 0;
  localparam int T1OSC_BIT  = 5;
  localparam int HIGH_SIDE_POLARITY_BIT   = 4;
  localparam int LOW_SIDE_POLARITY_BIT   = 3;
  localparam int PWM_RESET_STATE_SEL_BIT = 2;
  localparam int RESET_PIN_EN_BIT  = 7;
  localparam int EXCLK_BIT  = 4;
  localparam int PWM4_BIT   = 3;
  localparam int SSP_BIT    = 2;
  localparam int FAULT_INPUT_A_BIT   = 0;
  localparam int DEBUG_BIT  = 7;
  localparam int LVP_BIT    = 2;
  localparam int STVR_BIT   = 0;
  localparam int CPD_BIT    = 7;
  localparam int CPB_BIT    = 6;

  // brown-out trip levels in millivolts
  localparam logic [12:0] TRIP_4V5_MV = 13'h1194;
  localparam logic [12:0] TRIP_4V2_MV = 13'h1068;
  localparam logic [12:0] TRIP_2V7_MV = 13'h0A8C;

  localparam logic [2:0] PWMEN_OFF   = 3'h0;
  localparam logic [2:0] PWMEN_SIX   = 3'h4;
  localparam logic [2:0] PWMEN_EIGHT = 3'h5;

endpackage

// ### dcfd_config_tb.sv
// self-checking bench for the configuration byte bank and decoder
`timescale 1ns/1ps
module dcfd_config_tb;
  import dcfd_pkg::*;
  logic              clk_i, rst_n_i, wr_i, rd_i, bulk_erase_i, eight_output_pkg_i;
  logic              watchdog_soft_en_i, stack_full_i, stack_underflow_i;
  logic              external_reset_pin_i, watchdog_run_o, powerup_timer_en_o;
  logic [ADDR_W-1:0] addr_i;
  logic [7:0]        wdata_i, rdata_o, pwm_drive_i, pwm_force_i, pwm_force_active_i;
  logic [7:0]        pwm_pin_o, pwm_pin_oe_o;
  logic              brownout_reset_en_o, watchdog_window_en_o, timer1_osc_lowpower_o;
  logic              high_side_polarity_o, low_side_polarity_o, pwm_reset_state_sel_o;
  logic              reset_pin_en_o, external_reset_o, shared_pin_gp_o;
  logic              timer_ext_clock_pin_sel_o, pwm4_pin_sel_o, sync_serial_pin_sel_o;
  logic              fault_a_pin_sel_o, debug_en_o, single_supply_prog_en_o;
  logic              stack_error_reset_o, eeprom_protect_o, boot_block_protect_o;
  logic [1:0]        brownout_threshold_sel_o;
  logic [12:0]       brownout_trip_level_o;
  logic [3:0]        watchdog_postscale_sel_o, block_protect_o;
  logic [15:0]       watchdog_divide_o;
  logic [2:0]        pwm_output_enable_field_o;
  int                err_count, samples_checked;

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  dcfd_config dcfd_config_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .bulk_erase_i(bulk_erase_i), .rdata_o(rdata_o),
    .eight_output_pkg_i(eight_output_pkg_i), .watchdog_soft_en_i(watchdog_soft_en_i),
    .stack_full_i(stack_full_i), .stack_underflow_i(stack_underflow_i),
    .external_reset_pin_i(external_reset_pin_i), .pwm_drive_i(pwm_drive_i),
    .pwm_force_i(pwm_force_i), .pwm_force_active_i(pwm_force_active_i),
    .brownout_reset_en_o(brownout_reset_en_o),
    .brownout_threshold_sel_o(brownout_threshold_sel_o),
    .brownout_trip_level_o(brownout_trip_level_o), .powerup_timer_en_o(powerup_timer_en_o),
    .watchdog_window_en_o(watchdog_window_en_o),
    .watchdog_postscale_sel_o(watchdog_postscale_sel_o),
    .watchdog_divide_o(watchdog_divide_o), .watchdog_run_o(watchdog_run_o),
    .timer1_osc_lowpower_o(timer1_osc_lowpower_o),
    .high_side_polarity_o(high_side_polarity_o), .low_side_polarity_o(low_side_polarity_o),
    .pwm_reset_state_sel_o(pwm_reset_state_sel_o),
    .pwm_output_enable_field_o(pwm_output_enable_field_o),
    .pwm_pin_o(pwm_pin_o), .pwm_pin_oe_o(pwm_pin_oe_o), .reset_pin_en_o(reset_pin_en_o),
    .external_reset_o(external_reset_o), .shared_pin_gp_o(shared_pin_gp_o),
    .timer_ext_clock_pin_sel_o(timer_ext_clock_pin_sel_o), .pwm4_pin_sel_o(pwm4_pin_sel_o),
    .sync_serial_pin_sel_o(sync_serial_pin_sel_o), .fault_a_pin_sel_o(fault_a_pin_sel_o),
    .debug_en_o(debug_en_o), .single_supply_prog_en_o(single_supply_prog_en_o),
    .stack_error_reset_o(stack_error_reset_o), .block_protect_o(block_protect_o),
    .eeprom_protect_o(eeprom_protect_o), .boot_block_protect_o(boot_block_protect_o)
  );

  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [21:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [21:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 chk(16'(rdata_o), 16'(e));
  endtask

  // erase released two edges before reset so the last reset edge sees settled bytes
  task automatic do_reset(input logic erase);
    @(posedge clk_i);
    rst_n_i      <= 1'b0;
    bulk_erase_i <= erase;
    repeat (4) @(posedge clk_i);
    bulk_erase_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i      <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic pwm_chk(input logic [7:0] d, f, a, oe, input logic h, l);
    logic [7:0] act;
    act = (f & a) | (~f & d);
    @(posedge clk_i);
    pwm_drive_i        <= d;
    pwm_force_i        <= f;
    pwm_force_active_i <= a;
    repeat (2) @(posedge clk_i);
    #1 chk(16'(pwm_pin_o), 16'(~(act ^ {4{h, l}}) & oe));
  endtask

  task automatic pin_chk(input logic e);
    @(posedge clk_i);
    external_reset_pin_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1 chk(16'(external_reset_o), 16'(e));
    external_reset_pin_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1 chk(16'(shared_pin_gp_o), 16'(!e));
  endtask

  task automatic stk(input logic e);
    @(posedge clk_i);
    stack_full_i      <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 chk(16'(stack_error_reset_o), 16'(e));
    stack_full_i      <= 1'b0;
    stack_underflow_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 chk(16'(stack_error_reset_o), 16'(e));
    stack_underflow_i <= 1'b0;
  endtask

  function automatic logic [12:0] trip(input logic [1:0] c);
    return (c == 2'b00) ? TRIP_4V5_MV : (c == 2'b01) ? TRIP_4V2_MV : TRIP_2V7_MV;
  endfunction

  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    final_report();
  end

  initial begin
    logic [3:0] k;
    rst_n_i = 1'b0;
    bulk_erase_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = '0;
    wdata_i = 8'h00;
    eight_output_pkg_i = 1'b1;
    watchdog_soft_en_i = 1'b0;
    stack_full_i = 1'b0;
    stack_underflow_i = 1'b0;
    external_reset_pin_i = 1'b1;
    pwm_drive_i = 8'h00;
    pwm_force_i = 8'h00;
    pwm_force_active_i = 8'h00;
    err_count = 0;
    samples_checked = 0;
    // erased bank
    do_reset(1'b1);
    chk(16'(brownout_trip_level_o), 16'(TRIP_2V7_MV));
    chk(16'({brownout_reset_en_o, brownout_threshold_sel_o}), 16'h0007);
    chk(16'({watchdog_window_en_o, watchdog_divide_o[15], watchdog_run_o}), 16'h0003);
    chk(16'({timer1_osc_lowpower_o, powerup_timer_en_o}), 16'h0002);
    chk(16'({pwm_reset_state_sel_o, pwm_output_enable_field_o, pwm_pin_oe_o}), 16'h0800);
    chk(16'({reset_pin_en_o, timer_ext_clock_pin_sel_o, pwm4_pin_sel_o,
             sync_serial_pin_sel_o, fault_a_pin_sel_o}), 16'h001F);
    chk(16'({debug_en_o, single_supply_prog_en_o}), 16'h0001);
    chk(16'({block_protect_o, eeprom_protect_o, boot_block_protect_o}), 16'h0000);
    for (int j = 0; j < 7; j++) begin
      rd((j < 5) ? 22'h300002 + 22'(j) : 22'h300003 + 22'(j), REG_MASK[j]);
    end
    rd(22'h300000, 8'h00);
    wr(22'h300007, 8'hFF);
    rd(22'h300007, 8'h00);
    pwm_chk(8'hFF, 8'h00, 8'h00, 8'h00, 1'b1, 1'b1);
    stk(1'b1);
    pin_chk(1'b1);
    // every postscale and threshold code, package and soft enable varied
    for (int i = 0; i < 16; i++) begin
      k = i[3:0];
      wr(22'h300002, {4'h0, k[1:0], k[2], k[3]});
      wr(22'h300003, {2'b00, k[0], k, 1'b0});
      wr(22'h300004, 8'h18);
      eight_output_pkg_i <= k[0];
      watchdog_soft_en_i <= k[1];
      do_reset(1'b0);
      chk(16'(brownout_threshold_sel_o), 16'(k[1:0]));
      chk(16'(brownout_trip_level_o), 16'(trip(k[1:0])));
      chk(16'({brownout_reset_en_o, powerup_timer_en_o}), 16'({k[2], !k[3]}));
      chk(16'(watchdog_window_en_o), 16'(!k[0]));
      chk(16'(watchdog_postscale_sel_o), 16'(k));
      chk(watchdog_divide_o, 16'h0001 << k);
      chk(16'(watchdog_run_o), 16'(k[1]));
      chk(16'({pwm_output_enable_field_o, pwm_pin_oe_o}), k[0] ? 16'h05FF : 16'h043F);
      chk(16'({high_side_polarity_o, low_side_polarity_o}), 16'h0003);
      rd(22'h300003, {2'b00, k[0], k, 1'b0});
    end
    // programmed bank, settings hold until the next reset
    wr(22'h300002, 8'h00);
    wr(22'h300003, 8'h00);
    wr(22'h300004, 8'h00);
    wr(22'h300005, 8'h00);
    wr(22'h300006, 8'h00);
    wr(22'h300008, 8'h0A);
    wr(22'h300009, 8'h40);
    chk(16'({brownout_reset_en_o, watchdog_postscale_sel_o}), 16'h001F);
    eight_output_pkg_i <= 1'b1;
    watchdog_soft_en_i <= 1'b0;
    do_reset(1'b0);
    chk(16'({timer1_osc_lowpower_o, watchdog_run_o}), 16'h0000);
    chk(16'({pwm_reset_state_sel_o, pwm_output_enable_field_o, pwm_pin_oe_o}), 16'h05FF);
    chk(16'({reset_pin_en_o, timer_ext_clock_pin_sel_o, pwm4_pin_sel_o,
             sync_serial_pin_sel_o, fault_a_pin_sel_o}), 16'h0000);
    chk(16'({debug_en_o, single_supply_prog_en_o}), 16'h0002);
    chk(16'({block_protect_o, eeprom_protect_o, boot_block_protect_o}), 16'h0016);
    pwm_chk(8'h0F, 8'h00, 8'h00, 8'hFF, 1'b0, 1'b0);
    pwm_chk(8'h0F, 8'hF0, 8'h30, 8'hFF, 1'b0, 1'b0);
    stk(1'b0);
    pin_chk(1'b0);
    wr(22'h300008, 8'hFF);
    rd(22'h300008, 8'h0A);
    wr(22'h300009, 8'h80);
    rd(22'h300009, 8'h00);
    // mixed polarity on the six-output package
    wr(22'h300004, 8'h10);
    wr(22'h300005, 8'h9D);
    eight_output_pkg_i <= 1'b0;
    do_reset(1'b0);
    chk(16'({high_side_polarity_o, low_side_polarity_o}), 16'h0002);
    pwm_chk(8'h0F, 8'h00, 8'h00, 8'h3F, 1'b1, 1'b0);
    pwm_chk(8'h00, 8'h3C, 8'h14, 8'h3F, 1'b1, 1'b0);
    final_report();
  end
endmodule // dcfd_config_tb
